// file: hdl/status_query_pkg.sv
// Package: constants and carriers for the user-status query responder
package status_query_pkg;

  // Query request codes
  localparam logic [4:0] REQ_EVENT     = 5'h00;
  localparam logic [4:0] REQ_SUMMARY   = 5'h01;
  localparam logic [4:0] REQ_CALIB     = 5'h02;
  localparam logic [4:0] REQ_PEAK      = 5'h04;
  localparam logic [4:0] REQ_PEAK_CLR  = 5'h05;
  localparam logic [4:0] REQ_BUFFER    = 5'h06;
  localparam logic [4:0] REQ_DIGITAL   = 5'h09;
  localparam logic [4:0] REQ_MEMORY    = 5'h0A;
  localparam logic [4:0] REQ_ALARM     = 5'h0B;
  localparam logic [4:0] REQ_LASTCAL   = 5'h0C;
  localparam logic [4:0] REQ_CARD_ID   = 5'h0E;
  localparam logic [4:0] REQ_ACQ_FLAGS = 5'h12;

  // Event flag bit positions
  localparam int EV_POWER_ON    = 7;
  localparam int EV_BUF_3Q      = 6;
  localparam int EV_CMD_ERR     = 5;
  localparam int EV_EXEC_ERR    = 4;
  localparam int EV_DEV_ERR     = 3;
  localparam int EV_QUERY_ERR   = 2;
  localparam int EV_STOP        = 1;
  localparam int EV_ACQ_DONE    = 0;

  // Calibration mode field codes, bits 7:6
  localparam logic [1:0] CAL_NORMAL   = 2'h0;
  localparam logic [1:0] CAL_MEMTEST  = 2'h1;
  localparam logic [1:0] CAL_IDLE     = 2'h2;
  localparam logic [1:0] CAL_ACTIVE   = 2'h3;
  // Calibration error bit 2: the persistent one
  localparam int         CAL_BIT2     = 2;

  // Time stamping codes, flag bits 3:2
  localparam logic [1:0] TS_NONE      = 2'h0;
  localparam logic [1:0] TS_ABSOLUTE  = 2'h1;
  localparam logic [1:0] TS_RELATIVE  = 2'h2;

  // Acquisition state codes, flag bits 1:0
  localparam logic [1:0] ACQ_IDLE     = 2'h0;
  localparam logic [1:0] ACQ_ARMED    = 2'h1;
  localparam logic [1:0] ACQ_POST_TRG = 2'h2;
  localparam logic [1:0] ACQ_POST_STP = 2'h3;

  // Characters and widths
  localparam logic [7:0] CH_ZERO      = 8'h30;
  localparam logic [7:0] CH_COMMA     = 8'h2C;
  localparam logic [7:0] CH_NUMBER    = 8'h23;
  localparam int         NUM_SLOTS    = 31;
  localparam int         BUF_FIELDS   = 8;
  localparam int         NUM_DIGITS   = 3;
  localparam int         MEM_DIGITS   = 5;

  // Memory size option codes
  localparam logic [1:0] MEM_256K     = 2'h0;
  localparam logic [1:0] MEM_1M       = 2'h1;
  localparam logic [1:0] MEM_4M       = 2'h2;
  localparam logic [1:0] MEM_8M       = 2'h3;

  // Live status inputs from the acquisition side
  typedef struct packed {
    logic [7:0] event_set;     // Event pulses per bit
    logic [7:0] summary;       // Summary byte as produced
    logic [1:0] cal_mode;      // Calibration mode
    logic [5:0] cal_err_set;   // Calibration error pulses
    logic       calibrated;    // Calibration completed pulse
    logic       block_avail;   // Acquisition block available
    logic       default_pwrup; // Power up under defaults
    logic       alarm_stamp;   // Scan alarm stamping enabled
    logic [1:0] stamp_mode;    // Time stamping mode
    logic [1:0] acq_state;     // Acquisition state
    logic [1:0] mem_option;    // Installed memory option
    logic       any_config;    // Any channel configured
  } status_in_t;

  // Outgoing byte stream to the bus interface
  typedef struct packed {
    logic       valid;         // Byte present
    logic [7:0] data;          // Response character
    logic       last;          // Terminator byte
  } resp_byte_t;

endpackage : status_query_pkg

// file: hdl/response_mem.sv
// Response buffer: one queued reply held until talk addressing
module response_mem #(
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  // Clock and reset
  input  wire logic          ref_clk,
  input  wire logic          rst,
  // Write side
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [7:0]    wr_data,
  // Read side, registered
  input  wire logic [AW-1:0] rd_addr,
  output logic      [7:0]    rd_data
);
  logic [7:0] mem [DEPTH];  // Reply characters

  // Storage write and registered read
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : response_mem

// file: hdl/status_query_responder.sv
// User-status query responder: status registers and reply formatting
module status_query_responder
  import status_query_pkg::*;
#(
  parameter int         AW      = 6,
  parameter logic [7:0] DEF_TERM = 8'h0A
) (
  // Clock and reset
  input  wire logic          ref_clk,
  input  wire logic          rst,
  // Query command from the command parser
  input  wire logic          query_valid,
  input  wire logic [4:0]    query_code,
  input  wire logic [7:0]    query_term,
  // Talk addressing from the bus interface
  input  wire logic          talk_addressed,
  input  wire logic          talk_trigger_mode,
  input  wire logic          byte_taken,
  // Live status
  input  wire status_in_t    status,
  input  wire logic [7:0]    digital_pins,
  // Formatted data sources, per field or channel
  input  wire logic [7:0]    src_byte,
  input  wire logic          src_valid,
  input  wire logic          src_last,
  // Outputs
  output resp_byte_t         resp,
  output logic               src_req,
  output logic               peak_clear,
  output logic               conflict_err,
  output logic               talk_fire
);

  // Controller states
  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_NUM   = 5'b00010,
    S_SRC   = 5'b00100,
    S_READY = 5'b01000,
    S_SEND  = 5'b10000
  } state_t;

  // All registered state of this module; one struct keeps reset and
  // next-state handling in a single place
  typedef struct packed {
    // Controller and status registers
    state_t     st;             // Controller state
    logic [7:0] event_flags;    // Event byte, cleared on read
    logic [7:0] calibration_flags; // Mode mirror plus sticky error bits
    // Digital input pins, two stages against metastability
    logic [7:0] dig_s1_r;       // First synchroniser stage
    logic [7:0] dig_s2_r;       // Settled pin levels
    logic [7:0] num_r;          // Value being rendered
    logic [2:0] ndig_r;         // Digits still to write
    logic       prefix_r;       // Number sign still to write
    logic       mem_r;          // Rendering the memory size figure
    // Reply buffer pointers
    logic [AW-1:0] wptr_r;      // Next character slot to write
    logic [AW-1:0] rptr_r;      // Character now offered to the host
    logic [AW-1:0] len_r;       // Slot of the terminator
    logic [7:0] term_r;         // Terminator latched with the query
    // One-cycle pulses and handshake state
    logic       peak_clr_r;     // Clear peak readings
    logic       conflict_r;     // Card query refused
    logic       valid_r;        // Reply byte offered
    // Talk session that belongs to a status reply; keeps the
    // trigger quiet until the host drops talk addressing
    logic       talk_busy_r;
  } st_t;

  st_t cur_r;                   // Present state
  st_t cur_nxt;                 // Next state
  logic          wr_en;         // Buffer write strobe
  logic [7:0]    wr_data;       // Buffer write char
  logic [7:0]    rd_data;       // Buffer read char
  logic [13:0]   mem_code;      // Memory size as value

  // Reply buffer
  response_mem #(
    .DEPTH (1 << AW),
    .AW    (AW)
  ) u_mem (
    .ref_clk (ref_clk),
    .rst     (rst),
    .wr_en   (wr_en),
    .wr_addr (cur_r.wptr_r),
    .wr_data (wr_data),
    .rd_addr (cur_r.rptr_r),
    .rd_data (rd_data)
  );

  // Memory option to kilobyte figure
  // Widest figure needs fourteen bits, rendered as five digits
  always_comb begin
    case (status.mem_option)
      MEM_256K: mem_code = 14'h0100; // 256 KB
      MEM_1M:   mem_code = 14'h0400; // 1024 KB
      MEM_4M:   mem_code = 14'h1000; // 4096 KB
      default:  mem_code = 14'h2000; // 8192 KB
    endcase
  end

  // Decimal digit of a value by position
  function automatic logic [7:0] digit_of(input logic [13:0] v, input logic [2:0] pos);
    logic [13:0] q;
    q = v;
    for (int i = 0; i < 4; i++) begin
      if (3'(i) < pos) begin
        q = q / 14'd10;
      end
    end
    return CH_ZERO + 8'(q % 14'd10);
  endfunction : digit_of

  // Next-state logic
  always_comb begin
    cur_nxt         = cur_r;
    wr_en           = 1'b0;
    wr_data         = 8'h00;
    cur_nxt.peak_clr_r = 1'b0;
    cur_nxt.conflict_r = 1'b0;
    cur_nxt.dig_s1_r = digital_pins;
    cur_nxt.dig_s2_r = cur_r.dig_s1_r;
    // Talk session of a status reply lasts until talk addressing drops,
    // so the tail of a reply session cannot pass for a fresh talk
    cur_nxt.talk_busy_r = talk_addressed && (cur_r.talk_busy_r || cur_r.st != S_IDLE);
    // Hardware events set the event byte; set wins over clear
    cur_nxt.event_flags = cur_r.event_flags | status.event_set;
    // Calibration mode mirrors, errors accumulate
    cur_nxt.calibration_flags[7:6] = status.cal_mode;
    cur_nxt.calibration_flags[5:0] = cur_r.calibration_flags[5:0] | status.cal_err_set;
    if (status.calibrated) begin
      // Calibration error persists until calibrated
      cur_nxt.calibration_flags[CAL_BIT2] = status.cal_err_set[CAL_BIT2];
    end
    case (cur_r.st)
      // Accept a query whenever no reply is pending; acquisition runs on
      S_IDLE: begin
        if (query_valid) begin
          cur_nxt.wptr_r   = '0;
          cur_nxt.term_r   = query_term;
          cur_nxt.prefix_r = 1'b0;
          cur_nxt.ndig_r   = 3'(NUM_DIGITS);
          cur_nxt.mem_r    = query_code == REQ_MEMORY;
          cur_nxt.st       = S_NUM;
          case (query_code)
            REQ_EVENT: begin
              cur_nxt.num_r = cur_r.event_flags;
              cur_nxt.event_flags = status.event_set;
            end
            REQ_SUMMARY: begin
              cur_nxt.num_r = status.summary;
            end
            REQ_CALIB: begin
              cur_nxt.num_r = cur_r.calibration_flags;
              // Errors other than bit 2 clear; bit 2 waits for calibration
              // A calibration in the same cycle still clears bit 2
              cur_nxt.calibration_flags[5:0] =
                (cur_r.calibration_flags[5:0] & (status.calibrated ? 6'h00 : 6'(1 << CAL_BIT2)))
                | status.cal_err_set;
            end
            REQ_ACQ_FLAGS: begin
              cur_nxt.num_r = {status.block_avail, status.default_pwrup, 1'b0,
                               status.alarm_stamp, status.stamp_mode, status.acq_state};
            end
            REQ_DIGITAL: begin
              cur_nxt.num_r = cur_r.dig_s2_r;
            end
            REQ_MEMORY: begin
              cur_nxt.ndig_r = 3'(MEM_DIGITS);
            end
            REQ_CARD_ID: begin
              if (status.any_config) begin
                cur_nxt.conflict_r = 1'b1;
                cur_nxt.st         = S_IDLE;
              end else begin
                cur_nxt.st = S_SRC;
              end
            end
            REQ_LASTCAL: begin
              cur_nxt.prefix_r = 1'b1;
              cur_nxt.st       = S_SRC;
            end
            REQ_PEAK_CLR: begin
              cur_nxt.peak_clr_r = 1'b1;
              cur_nxt.st         = S_SRC;
            end
            default: begin
              // Peak, buffer status, alarm list come from sources
              cur_nxt.st = S_SRC;
            end
          endcase
          // Memory figure comes from the option strap, not the value byte
          if (query_code == REQ_MEMORY) begin
            cur_nxt.num_r = 8'h00;
          end
        end
      end
      // Render zero-padded decimal digits, most significant first
      S_NUM: begin
        wr_en   = 1'b1;
        // Every digit of the memory reply comes from the kilobyte figure
        if (cur_r.mem_r) begin
          wr_data = digit_of(mem_code, cur_r.ndig_r - 3'd1);
        end else begin
          wr_data = digit_of(14'(cur_r.num_r), cur_r.ndig_r - 3'd1);
        end
        cur_nxt.wptr_r = cur_r.wptr_r + 1'b1;
        cur_nxt.ndig_r = cur_r.ndig_r - 3'd1;
        if (cur_r.ndig_r == 3'd1) begin
          cur_nxt.st = S_READY;
        end
      end
      // Copy characters from field sources; number sign first if asked
      S_SRC: begin
        if (cur_r.prefix_r) begin
          wr_en            = 1'b1;
          wr_data          = CH_NUMBER;
          cur_nxt.prefix_r = 1'b0;
          cur_nxt.wptr_r   = cur_r.wptr_r + 1'b1;
        end else if (src_valid) begin
          wr_en          = 1'b1;
          wr_data        = src_byte;
          cur_nxt.wptr_r = cur_r.wptr_r + 1'b1;
          if (src_last || cur_r.wptr_r == '1 - 1'b1) begin
            cur_nxt.st = S_READY;
          end
        end
      end
      // Append terminator, then hold until talk addressed
      S_READY: begin
        wr_en          = 1'b1;
        wr_data        = cur_r.term_r;
        cur_nxt.len_r  = cur_r.wptr_r;
        cur_nxt.rptr_r = '0;
        cur_nxt.st     = S_SEND;
      end
      // Reply held until talk addressing collects it
      S_SEND: begin
        if (talk_addressed) begin
          cur_nxt.valid_r = 1'b1;
          if (byte_taken && cur_r.valid_r) begin
            cur_nxt.rptr_r = cur_r.rptr_r + 1'b1;
            cur_nxt.valid_r = 1'b0;
            if (cur_r.rptr_r == cur_r.len_r) begin
              cur_nxt.st    = S_IDLE;
              cur_nxt.len_r = '0;
            end
          end
        end else begin
          cur_nxt.valid_r = 1'b0;
        end
      end
      default: begin
        cur_nxt.st = S_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cur_r <= '{st: S_IDLE, event_flags: 8'h80, term_r: DEF_TERM, default: '0};
    end else begin
      cur_r <= cur_nxt;
    end
  end

  // Outputs; talk addressing for status never fires the trigger
  assign resp.valid   = cur_r.valid_r && (cur_r.st == S_SEND);
  assign resp.data    = rd_data;
  assign resp.last    = cur_r.rptr_r == cur_r.len_r;
  // No source request in the number-sign cycle: a character offered then
  // would be lost, as the source has no take strobe
  assign src_req      = cur_r.st == S_SRC && !cur_r.prefix_r;
  assign peak_clear   = cur_r.peak_clr_r;
  assign conflict_err = cur_r.conflict_r;
  // Only a talk session with no status reply behind it fires the trigger
  assign talk_fire    = talk_addressed && talk_trigger_mode && cur_r.st == S_IDLE
                        && !cur_r.talk_busy_r;

endmodule : status_query_responder

// file: verif/status_query_assertions.sv
// Checker: port-level timing properties of the status query responder
module status_query_assertions
  import status_query_pkg::*;
(
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst,
  // Query and talk side
  input wire logic       query_valid,
  input wire logic [4:0] query_code,
  input wire logic [7:0] query_term,
  input wire logic       talk_addressed,
  input wire logic       talk_trigger_mode,
  input wire logic       byte_taken,
  // Live status and sources
  input wire status_in_t status,
  input wire logic [7:0] digital_pins,
  input wire logic [7:0] src_byte,
  input wire logic       src_valid,
  input wire logic       src_last,
  // Outputs under watch
  input wire resp_byte_t resp,
  input wire logic       src_req,
  input wire logic       peak_clear,
  input wire logic       conflict_err,
  input wire logic       talk_fire
);
  timeunit 1ns;
  timeprecision 100ps;

  // One domain, so clock and reset are given once
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_valid_needs_talk: assert property (resp.valid |-> $past(talk_addressed))
    else $error("reply byte shown without talk addressing");
  a_byte_stands: assert property (resp.valid && !byte_taken && talk_addressed |=> resp.valid && $stable(resp.data))
    else $error("reply byte changed before it was taken");
  a_gap_after_take: assert property (resp.valid && byte_taken |=> !resp.valid)
    else $error("reply byte not advanced after take");
  a_term_held: assert property (resp.valid && resp.last && !byte_taken && talk_addressed |=> resp.last)
    else $error("terminator byte dropped before take");
  a_reply_no_fire: assert property (resp.valid |-> !talk_fire)
    else $error("talk trigger fired while reply pending");
  a_fire_needs_mode: assert property (talk_fire |-> talk_addressed && talk_trigger_mode)
    else $error("talk trigger without talk mode and address");
  a_peak_one_pulse: assert property (peak_clear |=> !peak_clear)
    else $error("peak clear longer than one cycle");
  a_conflict_pulse: assert property (conflict_err |=> !conflict_err)
    else $error("conflict longer than one cycle");
  a_conflict_cause: assert property ($rose(conflict_err) |->
    $past(query_valid) && $past(query_code) == REQ_CARD_ID && $past(status.any_config))
    else $error("conflict without a card query on configured channels");
  a_conflict_silent: assert property (conflict_err |=> (!resp.valid) [*4])
    else $error("reply produced after conflict");
endmodule : status_query_assertions

// file: verif/host_model.sv
// Host controller model: talk-addresses the unit and takes reply bytes
module host_model
  import status_query_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Reply stream from the unit
  input  wire resp_byte_t resp,
  // Talk addressing toward the unit
  output logic            talk_addressed,
  output logic            byte_taken
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle bus: not talker, nothing taken
  initial begin
    talk_addressed = 1'b0;
    byte_taken     = 1'b0;
  end

  // Collect one whole reply; the reply is only delivered on talk addressing
  task automatic collect(output logic [39:0] body, output int n, output logic [7:0] term);
    bit done;
    body = '0;
    n    = 0;
    term = 8'h00;
    done = 1'b0;
    #1 talk_addressed = 1'b1;
    // Bounded so a dead reply cannot hang the host
    for (int k = 0; k < 200 && !done; k++) begin
      @(posedge ref_clk);
      #1;
      if (byte_taken) begin
        byte_taken = 1'b0;
      end else if (resp.valid === 1'b1) begin
        if (resp.last === 1'b1) begin
          term = resp.data;
          done = 1'b1;
        end else begin
          body = {body[31:0], resp.data};
          n++;
        end
        byte_taken = 1'b1;
      end
    end
    @(posedge ref_clk);
    #1 byte_taken = 1'b0;
    talk_addressed = 1'b0;
    if (!done) n = -1;
  endtask : collect
endmodule : host_model

// file: verif/status_query_responder_tb.sv
// Testbench: drives queries and checks replies against a reference model
module status_query_responder_tb
  import status_query_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // Design connections
  logic       ref_clk, rst, query_valid, talk_trigger_mode, src_valid, src_last;
  logic       talk_addressed, byte_taken, src_req, peak_clear, conflict_err, talk_fire;
  logic [4:0] query_code;
  logic [7:0] query_term, digital_pins, src_byte;
  status_in_t status;
  resp_byte_t resp;
  // Bench bookkeeping
  int         failures, tests_run, seed, pk, cf, pb, e, v, sc, tf;

  status_query_responder status_query_responder_i (.ref_clk(ref_clk), .rst(rst), .query_valid(query_valid),
    .query_code(query_code), .query_term(query_term), .talk_addressed(talk_addressed),
    .talk_trigger_mode(talk_trigger_mode), .byte_taken(byte_taken), .status(status), .digital_pins(digital_pins),
    .src_byte(src_byte), .src_valid(src_valid), .src_last(src_last), .resp(resp), .src_req(src_req),
    .peak_clear(peak_clear), .conflict_err(conflict_err), .talk_fire(talk_fire));
  host_model host_model_i (.ref_clk(ref_clk), .rst(rst), .resp(resp), .talk_addressed(talk_addressed),
    .byte_taken(byte_taken));

  // 250 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Pulse counters and a two-character source for all source-fed replies
  always @(posedge ref_clk) begin
    // Outputs are read once settled, just after the edge that launched them
    #1;
    if (peak_clear === 1'b1) pk++;
    if (conflict_err === 1'b1) cf++;
    if (talk_fire === 1'b1) tf++;
    src_valid = (src_req === 1'b1);
    src_byte = 8'h41 + 8'(sc);
    src_last = src_valid && sc == 1;
    sc = src_valid ? sc + 1 : 0;
  end

  // Decimal digits, most significant first, as the reference renders them
  function automatic logic [39:0] dec(int x, int nd);
    logic [39:0] r;
    r = '0;
    for (int i = 0; i < nd; i++) begin
      r[8*i +: 8] = 8'h30 + 8'(x % 10);
      x = x / 10;
    end
    return r;
  endfunction : dec

  // Verdict in one place
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  // Compare a single flag
  task automatic check_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_bit

  // Issue a query with a random terminator, collect, compare body, length, terminator
  task automatic ask(input logic [4:0] code, input logic [39:0] exp, input int nd);
    logic [39:0] got;
    logic [7:0]  tg, tm;
    int          n;
    tm = 8'($random(seed));
    @(posedge ref_clk);
    #1 query_valid = 1'b1;
    query_code = code;
    query_term = tm;
    @(posedge ref_clk);
    #1 query_valid = 1'b0;
    // Reply is written within a few cycles and then held
    repeat (8) @(posedge ref_clk);
    host_model_i.collect(got, n, tg);
    tests_run++;
    if (got !== exp || n != nd || tg !== tm) begin
      failures++;
      $display("unexpected at %0t: got %h/%0h/%h expected %h/%0h/%h", $time, got, n, tg, exp, nd, tm);
    end
  endtask : ask

  // One-cycle pulse on a status pulse field
  task automatic pulse(input int which, input logic [7:0] x);
    @(posedge ref_clk);
    #1 if (which == 0) status.event_set = x;
    else if (which == 1) status.cal_err_set = x[5:0];
    else status.calibrated = 1'b1;
    @(posedge ref_clk);
    #1 status.event_set = '0;
    status.cal_err_set = '0;
    status.calibrated = 1'b0;
  endtask : pulse

  // Main sequence
  initial begin
    seed = 32'h0b91;
    {rst, query_valid, query_code, query_term, talk_trigger_mode} = {1'b1, 14'h0000, 1'b1};
    {status, digital_pins, src_byte, src_valid, src_last} = '0;
    {failures, tests_run, pk, cf, pb, sc} = '0;
    repeat (3) @(posedge ref_clk);
    #1 rst = 1'b0;
    ask(REQ_EVENT, dec(128, 3), 3);
    ask(REQ_EVENT, dec(0, 3), 3);
    v = $random(seed) & 255;
    pulse(0, 8'(v));
    ask(REQ_EVENT, dec(v, 3), 3);
    status.summary = 8'($random(seed));
    ask(REQ_SUMMARY, dec(status.summary, 3), 3);
    ask(REQ_SUMMARY, dec(status.summary, 3), 3);
    // Every mode; bit 2 survives the read until calibrated
    for (int m = 0; m < 4; m++) begin
      status.cal_mode = 2'(m);
      e = $random(seed) & 63;
      pulse(1, 8'(e));
      ask(REQ_CALIB, dec(m * 64 + (e | pb), 3), 3);
      pb = (e | pb) & 4;
      ask(REQ_CALIB, dec(m * 64 + pb, 3), 3);
      pulse(2, 8'h00);
      pb = 0;
    end
    // Flag byte fields, bit 5 always zero
    for (int k = 0; k < 6; k++) begin
      v = $random(seed);
      {status.block_avail, status.default_pwrup, status.alarm_stamp} = 3'(v);
      status.stamp_mode = 2'(k % 3);
      status.acq_state = 2'(k % 4);
      ask(REQ_ACQ_FLAGS, dec(((v & 6) << 5) + ((v & 1) << 4) + (k % 3) * 4 + k % 4, 3), 3);
    end
    for (int m = 0; m < 4; m++) begin
      status.mem_option = 2'(m);
      ask(REQ_MEMORY, dec(m == 3 ? 8192 : 256 << (2 * m), 5), 5);
    end
    ask(REQ_PEAK, 40'h4142, 2);
    check_bit(pk == 0, 1'b1);
    ask(REQ_PEAK_CLR, 40'h4142, 2);
    check_bit(pk == 1, 1'b1);
    // Source-fed replies pass characters in order; number sign leads only REQ_LASTCAL
    ask(REQ_BUFFER, 40'h4142, 2);
    ask(REQ_ALARM, 40'h4142, 2);
    ask(REQ_LASTCAL, 40'h234142, 3);
    ask(REQ_CARD_ID, 40'h4142, 2);
    // Pins pass two synchroniser stages before the query samples them
    digital_pins = 8'($random(seed));
    repeat (2) @(posedge ref_clk);
    ask(REQ_DIGITAL, dec(digital_pins, 3), 3);
    status.any_config = 1'b1;
    @(posedge ref_clk);
    #1 query_valid = 1'b1;
    query_code = REQ_CARD_ID;
    @(posedge ref_clk);
    #1 query_valid = 1'b0;
    repeat (6) @(posedge ref_clk);
    check_bit(cf == 1, 1'b1);
    check_bit(tf == 0, 1'b1);
    report_and_stop;
  end

  // Watchdog well beyond the expected run
  initial begin
    #80000;
    failures++;
    report_and_stop;
  end
endmodule : status_query_responder_tb

bind status_query_responder status_query_assertions status_query_assertions_i (.ref_clk(ref_clk), .rst(rst),
  .query_valid(query_valid), .query_code(query_code), .query_term(query_term), .talk_addressed(talk_addressed),
  .talk_trigger_mode(talk_trigger_mode), .byte_taken(byte_taken), .status(status), .digital_pins(digital_pins),
  .src_byte(src_byte), .src_valid(src_valid), .src_last(src_last), .resp(resp), .src_req(src_req),
  .peak_clear(peak_clear), .conflict_err(conflict_err), .talk_fire(talk_fire));
